// ---- hw/fdg_pkg.sv ----
// constants, register map and datagram layout for the slave diagnostic framer
//
// What this block does
// - status2 bit0: new parameters and configuration needed
// - status2 bit1: static diagnostic pending, operation blocked
// - status2 bit2 always one: slave present
// - status2 bit3 mirrors watchdog enable
// - status2 bits4/5: freeze and sync commands received
// - status2 bit6 always zero
// - status2 bit7: slave disabled, out of cyclic processing
// - status3 bits0 to 6 always zero
// - status3 bit7: diagnostic message overflow
// - byte3 holds configuring master's bus address
// - byte3 reads all ones when unconfigured
// - bytes4/5 device identifier, fixed family then register-set variant
// - identifier diagnostics flag ranges that got entries
// - module status follows, at most thirteen bytes
// - device area starts at y, max twenty bytes
// - process alarm writes type 02 at y+1
// - process alarm copies four payload bytes from y+4
// - state-change alarm writes type 01, copies four payload bytes from y+4
// - state-change alarm bytes y+8 to y+19 zero
// - status1 bit3 set run-to-stop, clear stop-to-run
package fdg_pkg;

    // register byte addresses
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_MADDR  = 8'h04;
    localparam logic [7:0] OFF_ID     = 8'h08;
    localparam logic [7:0] OFF_RANGE  = 8'h0C;
    localparam logic [7:0] OFF_ALARM  = 8'h10;
    localparam logic [7:0] OFF_ADATA  = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // control register fields
    localparam int CTRL_NEED_PARAM = 0;
    localparam int CTRL_STATIC     = 1;
    localparam int CTRL_WATCHDOG   = 3;
    localparam int CTRL_DISABLED   = 7;
    localparam int CTRL_OVERFLOW   = 8;
    localparam int CTRL_CONFIGURED = 9;
    localparam int CTRL_WIDTH      = 10;

    // alarm command fields
    localparam int ALM_PROCESS   = 0;
    localparam int ALM_STATE     = 1;
    localparam int ALM_RUN_STOP  = 2;

    // status register fields (freeze and sync are write-one-to-clear)
    localparam int STS_FREEZE  = 0;
    localparam int STS_SYNC    = 1;
    localparam int STS_PENDING = 2;
    localparam int STS_BUSY    = 3;
    localparam int STS_STATIC  = 4;

    // station status bit positions
    localparam int ST1_RUN_STOP = 3;
    localparam int ST2_NEED_PRM = 0;
    localparam int ST2_STATIC   = 1;
    localparam int ST2_PRESENT  = 2;
    localparam int ST2_WATCHDOG = 3;
    localparam int ST2_FREEZE   = 4;
    localparam int ST2_SYNC     = 5;
    localparam int ST2_DISABLED = 7;
    localparam int ST3_OVERFLOW = 7;

    // datagram layout, byte indices
    localparam logic [5:0] B_ST1      = 6'h00;
    localparam logic [5:0] B_ST2      = 6'h01;
    localparam logic [5:0] B_ST3      = 6'h02;
    localparam logic [5:0] B_MADDR    = 6'h03;
    localparam logic [5:0] B_ID_HI    = 6'h04;
    localparam logic [5:0] B_ID_LO    = 6'h05;
    localparam logic [5:0] B_IDENT    = 6'h06;
    localparam logic [5:0] B_MOD      = 6'h08;
    localparam logic [5:0] MOD_LEN    = 6'h05;
    localparam logic [5:0] MOD_MAX    = 6'h0D;
    localparam logic [5:0] B_DEV      = 6'h0D;
    localparam logic [5:0] DEV_LEN    = 6'h14;
    localparam logic [5:0] LEN_PLAIN  = 6'h0D;
    localparam logic [5:0] LEN_ALARM  = 6'h21;

    // header and code values
    localparam logic [7:0] IDENT_HDR  = 8'h42;
    localparam logic [7:0] MOD_HDR    = 8'h05;
    localparam logic [7:0] MOD_TYPE   = 8'h82;
    localparam logic [7:0] DEV_HDR    = 8'h14;
    localparam logic [7:0] TYPE_PROC  = 8'h02;
    localparam logic [7:0] TYPE_DIAG  = 8'h01;
    localparam logic [7:0] NO_MASTER  = 8'hFF;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;

    // sender states
    typedef enum logic [0:0] {
        FDG_IDLE = 1'b0,
        FDG_SEND = 1'b1
    } fdg_state_e;

endpackage

// ---- hw/fdg_pin_sync.sv ----
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module fdg_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             reset_n_in,
    // raw pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    initial begin
        if (WIDTH < 1) begin
            $error("fdg_pin_sync: WIDTH must be at least 1");
        end
    end

    // shift chain; stage1 feeds only stage2
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // level changes only where stages two and three agree
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            level_out <= '0;
        end else begin
            level_out <= (stage2 & stage3) | (level_out & (stage2 | stage3));
        end
    end

endmodule

// ---- hw/fdg_diag_frame.sv ----
// slave diagnostic datagram framer with AHB-Lite register slave
`timescale 1ns/1ns
module fdg_diag_frame #(
    parameter logic [7:0] ID_FAMILY = 8'h5A,  // arbitrary value
    parameter int         N_RANGES  = 4
) (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // master control commands and diagnostic request pins
    input  wire logic        freeze_cmd_in,
    input  wire logic        sync_cmd_in,
    input  wire logic        diag_req_in,
    // datagram byte stream
    output logic      [7:0]  diag_byte_out,
    output logic             diag_valid_out,
    output logic             diag_last_out,
    // operation permitted
    output logic             run_enable_out
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    initial begin
        if (N_RANGES < 1 || N_RANGES > 4) begin
            $error("fdg_diag_frame: N_RANGES must be 1 to 4");
        end
        if (fdg_pkg::MOD_LEN > fdg_pkg::MOD_MAX) begin
            $error("fdg_diag_frame: module status longer than allowed");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [fdg_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [7:0]                     master_addr;
    logic [7:0]                     id_variant;
    logic [N_RANGES-1:0]            range_entry;

    // alarm and flags
    logic [31:0]                    alarm_data;
    logic                           alarm_pending;
    logic                           alarm_is_state;
    logic                           alarm_run_stop;
    logic                           freeze_seen;
    logic                           sync_seen;

    // bus
    logic                           wr_pend;
    logic [7:0]                     wr_addr;

    // sender
    fdg_pkg::fdg_state_e            state;
    logic [5:0]                     idx;
    logic [5:0]                     frame_len;
    logic                           frame_alarm;

    // pin edges, byte mux
    logic [2:0]                     pin_level;
    logic [2:0]                     pin_prev;
    logic [7:0]                     cur_byte;
    logic                           addr_phase;
    logic                           wr_data;
    logic                           freeze_rise;
    logic                           sync_rise;
    logic                           req_rise;
    logic                           frame_done;

    ////////////////////////////////////////////////////////////////////////
    // pin inputs

    fdg_pin_sync #(
        .WIDTH (3)
    ) u_pins (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .pin_in     ({diag_req_in, sync_cmd_in, freeze_cmd_in}),
        .level_out  (pin_level)
    );

    // rising edges of filtered pin levels
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            pin_prev <= 3'h0;
        end else begin
            pin_prev <= pin_level;
        end
    end

    assign freeze_rise = pin_level[0] & ~pin_prev[0];
    assign sync_rise   = pin_level[1] & ~pin_prev[1];
    assign req_rise    = pin_level[2] & ~pin_prev[2];

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    function automatic logic [31:0] reg_read(input logic [7:0] addr);
        logic [31:0] val;
        val = 32'h0000_0000;
        unique case (addr)
            fdg_pkg::OFF_CTRL:   val[fdg_pkg::CTRL_WIDTH-1:0] = ctrl;
            fdg_pkg::OFF_MADDR:  val[7:0] = master_addr;
            fdg_pkg::OFF_ID:     val[7:0] = id_variant;
            fdg_pkg::OFF_RANGE:  val[N_RANGES-1:0] = range_entry;
            fdg_pkg::OFF_ALARM: begin
                val[fdg_pkg::ALM_PROCESS]  = alarm_pending & ~alarm_is_state;
                val[fdg_pkg::ALM_STATE]    = alarm_pending & alarm_is_state;
                val[fdg_pkg::ALM_RUN_STOP] = alarm_run_stop;
            end
            fdg_pkg::OFF_ADATA:  val = alarm_data;
            fdg_pkg::OFF_STATUS: begin
                val[fdg_pkg::STS_FREEZE]  = freeze_seen;
                val[fdg_pkg::STS_SYNC]    = sync_seen;
                val[fdg_pkg::STS_PENDING] = alarm_pending;
                val[fdg_pkg::STS_BUSY]    = (state == fdg_pkg::FDG_SEND);
                val[fdg_pkg::STS_STATIC]  = ctrl[fdg_pkg::CTRL_STATIC];
            end
            default:             val = 32'h0000_0000;
        endcase
        return val;
    endfunction

    assign addr_phase = hsel_in & htrans_in[1] & hready_in;
    assign wr_data    = wr_pend & hready_in;

    // address phase capture; zero wait states, always okay
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            wr_pend       <= 1'b0;
            wr_addr       <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            if (hready_in) begin
                wr_pend <= addr_phase & hwrite_in;
                wr_addr <= {haddr_in[7:2], 2'b00};
            end
            if (addr_phase && !hwrite_in) begin
                hrdata_out <= reg_read({haddr_in[7:2], 2'b00});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    // plain read/write registers steering the datagram
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            ctrl        <= '0;
            master_addr <= 8'h00;
            id_variant  <= 8'h00;
            range_entry <= '0;
            alarm_data  <= 32'h0000_0000;
        end else if (wr_data) begin
            unique case (wr_addr)
                fdg_pkg::OFF_CTRL:  ctrl        <= hwdata_in[fdg_pkg::CTRL_WIDTH-1:0];
                fdg_pkg::OFF_MADDR: master_addr <= hwdata_in[7:0];
                fdg_pkg::OFF_ID:    id_variant  <= hwdata_in[7:0];
                fdg_pkg::OFF_RANGE: range_entry <= hwdata_in[N_RANGES-1:0];
                fdg_pkg::OFF_ADATA: alarm_data  <= hwdata_in;
                default:            ctrl        <= ctrl;
            endcase
        end
    end

    // frozen and synced flags; a new command wins over a clear
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            freeze_seen <= 1'b0;
            sync_seen   <= 1'b0;
        end else begin
            if (freeze_rise) begin
                freeze_seen <= 1'b1;
            end else if (wr_data && wr_addr == fdg_pkg::OFF_STATUS
                         && hwdata_in[fdg_pkg::STS_FREEZE]) begin
                freeze_seen <= 1'b0;
            end
            if (sync_rise) begin
                sync_seen <= 1'b1;
            end else if (wr_data && wr_addr == fdg_pkg::OFF_STATUS
                         && hwdata_in[fdg_pkg::STS_SYNC]) begin
                sync_seen <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm slot

    // a raise call arms the slot; a finished frame that carried it frees it
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            alarm_pending  <= 1'b0;
            alarm_is_state <= 1'b0;
            alarm_run_stop <= 1'b0;
        end else if (wr_data && wr_addr == fdg_pkg::OFF_ALARM
                     && !alarm_pending && (state == fdg_pkg::FDG_IDLE)
                     && (hwdata_in[fdg_pkg::ALM_PROCESS]
                         || hwdata_in[fdg_pkg::ALM_STATE])) begin
            alarm_pending  <= 1'b1;
            alarm_is_state <= hwdata_in[fdg_pkg::ALM_STATE]
                              & ~hwdata_in[fdg_pkg::ALM_PROCESS];
            alarm_run_stop <= hwdata_in[fdg_pkg::ALM_RUN_STOP];
        end else if (frame_done && frame_alarm) begin
            alarm_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // datagram contents

    // byte at a given datagram position
    always_comb begin
        cur_byte = fdg_pkg::ZERO_BYTE;
        if (idx == fdg_pkg::B_ST1) begin
            cur_byte[fdg_pkg::ST1_RUN_STOP] = frame_alarm & alarm_is_state
                                              & alarm_run_stop;
        end else if (idx == fdg_pkg::B_ST2) begin
            cur_byte[fdg_pkg::ST2_NEED_PRM] = ctrl[fdg_pkg::CTRL_NEED_PARAM];
            cur_byte[fdg_pkg::ST2_STATIC]   = ctrl[fdg_pkg::CTRL_STATIC];
            cur_byte[fdg_pkg::ST2_PRESENT]  = 1'b1;
            cur_byte[fdg_pkg::ST2_WATCHDOG] = ctrl[fdg_pkg::CTRL_WATCHDOG];
            cur_byte[fdg_pkg::ST2_FREEZE]   = freeze_seen;
            cur_byte[fdg_pkg::ST2_SYNC]     = sync_seen;
            cur_byte[fdg_pkg::ST2_DISABLED] = ctrl[fdg_pkg::CTRL_DISABLED];
        end else if (idx == fdg_pkg::B_ST3) begin
            cur_byte[fdg_pkg::ST3_OVERFLOW] = ctrl[fdg_pkg::CTRL_OVERFLOW];
        end else if (idx == fdg_pkg::B_MADDR) begin
            cur_byte = ctrl[fdg_pkg::CTRL_CONFIGURED] ? master_addr
                                                      : fdg_pkg::NO_MASTER;
        end else if (idx == fdg_pkg::B_ID_HI) begin
            cur_byte = ID_FAMILY;
        end else if (idx == fdg_pkg::B_ID_LO) begin
            cur_byte = id_variant;
        end else if (idx == fdg_pkg::B_IDENT) begin
            cur_byte = fdg_pkg::IDENT_HDR;
        end else if (idx == fdg_pkg::B_IDENT + 6'h01) begin
            cur_byte[N_RANGES-1:0] = range_entry;
        end else if (idx == fdg_pkg::B_MOD) begin
            cur_byte = fdg_pkg::MOD_HDR;
        end else if (idx == fdg_pkg::B_MOD + 6'h01) begin
            cur_byte = fdg_pkg::MOD_TYPE;
        end else if (idx == fdg_pkg::B_MOD + 6'h04) begin
            // two status bits per range, 00 = ok, 11 = entry pending
            for (int r = 0; r < N_RANGES; r++) begin
                cur_byte[2*r]   = range_entry[r];
                cur_byte[2*r+1] = range_entry[r];
            end
        end else if (idx == fdg_pkg::B_DEV) begin
            cur_byte = fdg_pkg::DEV_HDR;
        end else if (idx == fdg_pkg::B_DEV + 6'h01) begin
            cur_byte = alarm_is_state ? fdg_pkg::TYPE_DIAG
                                      : fdg_pkg::TYPE_PROC;
        end else if (idx >= fdg_pkg::B_DEV + 6'h04 && idx < fdg_pkg::B_DEV + 6'h08) begin
            // payload passed through untouched, first byte first
            unique case (2'(idx - fdg_pkg::B_DEV))
                2'h0:    cur_byte = alarm_data[31:24];
                2'h1:    cur_byte = alarm_data[23:16];
                2'h2:    cur_byte = alarm_data[15:8];
                default: cur_byte = alarm_data[7:0];
            endcase
        end else begin
            cur_byte = fdg_pkg::ZERO_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sender

    assign frame_done = (state == fdg_pkg::FDG_SEND) && (idx == frame_len - 6'h01);

    // one byte per clock in ascending order, status1 first
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state       <= fdg_pkg::FDG_IDLE;
            idx         <= 6'h00;
            frame_len   <= fdg_pkg::LEN_PLAIN;
            frame_alarm <= 1'b0;
        end else begin
            unique case (state)
                fdg_pkg::FDG_IDLE: begin
                    idx <= fdg_pkg::B_ST1;
                    if (req_rise) begin
                        state       <= fdg_pkg::FDG_SEND;
                        frame_alarm <= alarm_pending;
                        frame_len   <= alarm_pending ? fdg_pkg::LEN_ALARM
                                                     : fdg_pkg::LEN_PLAIN;
                    end
                end
                fdg_pkg::FDG_SEND: begin
                    if (frame_done) begin
                        state <= fdg_pkg::FDG_IDLE;
                        idx   <= fdg_pkg::B_ST1;
                    end else begin
                        idx <= idx + 6'h01;
                    end
                end
            endcase
        end
    end

    // registered stream outputs
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            diag_byte_out  <= 8'h00;
            diag_valid_out <= 1'b0;
            diag_last_out  <= 1'b0;
        end else begin
            diag_valid_out <= (state == fdg_pkg::FDG_SEND);
            diag_last_out  <= frame_done;
            diag_byte_out  <= (state == fdg_pkg::FDG_SEND) ? cur_byte : 8'h00;
        end
    end

    // operation held off while a static diagnostic stands
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            run_enable_out <= 1'b0;
        end else begin
            run_enable_out <= ~ctrl[fdg_pkg::CTRL_STATIC]
                              & ~ctrl[fdg_pkg::CTRL_DISABLED];
        end
    end

endmodule

// ---- testbench/fdg_diag_frame_props.sv ----
// assertions on the diagnostic byte stream of the framer
`timescale 1ns/1ns
module fdg_diag_frame_props (
    // clock and reset
    input wire logic       clock_in,
    input wire logic       reset_n_in,
    // request pin and byte stream
    input wire logic       diag_req_in,
    input wire logic [7:0] diag_byte_out,
    input wire logic       diag_valid_out,
    input wire logic       diag_last_out
);
    logic [5:0] idx;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // position of the byte now on the stream
    always_ff @(posedge clock_in) begin
        if (!reset_n_in || !diag_valid_out || diag_last_out) begin
            idx <= 6'h00;
        end else begin
            idx <= idx + 6'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence frame_start;
        !diag_valid_out ##1 diag_valid_out;
    endsequence
    sequence req_idle;
        $rose(diag_req_in) && !diag_valid_out;
    endsequence
    a_req_answer: assert property (req_idle |-> ##[3:12] diag_valid_out)
        else $error("no frame after request");
    a_valid_run: assert property (frame_start |-> diag_valid_out [*8])
        else $error("stream gap inside frame");
    a_last_ends: assert property (diag_last_out |=> !diag_valid_out)
        else $error("stream runs past last byte");
    a_idle_zero: assert property (!diag_valid_out |-> !diag_last_out && diag_byte_out == 8'h00)
        else $error("idle stream not quiet");
    a_frame_len: assert property (diag_last_out |-> idx == 6'h0C || idx == 6'h20)
        else $error("frame length wrong");
    a_st1_bits: assert property (diag_valid_out && idx == 6'h00 |-> (diag_byte_out & 8'hF7) == 8'h00)
        else $error("status one stray bits");
    a_st2_fixed: assert property (diag_valid_out && idx == 6'h01 |-> diag_byte_out[2] && !diag_byte_out[6])
        else $error("status two fixed bits");
    a_st3_zero: assert property (diag_valid_out && idx == 6'h02 |-> diag_byte_out[6:0] == 7'h00)
        else $error("status three low bits");
    a_type_code: assert property (diag_valid_out && idx == 6'h0E |-> diag_byte_out inside {8'h01, 8'h02})
        else $error("alarm type code");
    a_tail_zero: assert property (diag_valid_out && idx >= 6'h15 |-> diag_byte_out == 8'h00)
        else $error("alarm tail not zero");
endmodule

// ---- testbench/fdg_master_model.sv ----
// bus master model: request and command pins, frame capture
`timescale 1ns/1ns
module fdg_master_model (
    // clock
    input  wire logic       clock_in,
    // datagram stream from the slave
    input  wire logic [7:0] diag_byte_out,
    input  wire logic       diag_valid_out,
    input  wire logic       diag_last_out,
    // request and control command pins
    output logic            diag_req_in,
    output logic            freeze_cmd_in,
    output logic            sync_cmd_in
);
    logic [7:0] frame [0:63];
    logic [5:0] cnt = 6'h00;
    int         got_len = 0;
    int         frames = 0;
    initial {sync_cmd_in, freeze_cmd_in, diag_req_in} = 3'h0;
    // store bytes in arrival order, close on the last one
    always @(posedge clock_in) begin
        if (diag_valid_out === 1'b1) begin
            frame[cnt] <= diag_byte_out;
            cnt <= diag_last_out ? 6'h00 : cnt + 6'h01;
            if (diag_last_out) begin
                got_len <= cnt + 1;
                frames <= frames + 1;
            end
        end
    end
    // pin held past the input filter, then idle low
    task automatic pulse(input int which);
        @(posedge clock_in);
        {sync_cmd_in, freeze_cmd_in, diag_req_in} <= 3'(1 << which);
        repeat (8) @(posedge clock_in);
        {sync_cmd_in, freeze_cmd_in, diag_req_in} <= 3'h0;
        repeat (8) @(posedge clock_in);
    endtask
endmodule

// ---- testbench/tb_fieldbus_slave_diag_frame.sv ----
// top testbench for the slave diagnostic framer
`timescale 1ns/1ns
module tb_fieldbus_slave_diag_frame;
    localparam logic [7:0] FAM = 8'h3C; // arbitrary value
    logic        clock_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0]  htrans_in = 2'b00;
    logic        hwrite_in = 1'b0;
    logic [31:0] hwdata_in = 32'h0;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        hresp_out;
    wire logic   freeze_cmd_in;
    wire logic   sync_cmd_in;
    wire logic   diag_req_in;
    logic [7:0]  diag_byte_out;
    logic        diag_valid_out;
    logic        diag_last_out;
    logic        run_enable_out;
    logic [7:0]  ex [0:32];
    logic [9:0]  ctrl = 10'h000;
    logic [7:0]  maddr = 8'h00;
    logic [7:0]  vid = 8'h00;
    logic [3:0]  rng = 4'h0;
    logic [31:0] adata;
    logic [31:0] v;
    logic        frz = 1'b0;
    logic        syn = 1'b0;
    logic        rs = 1'b0;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          seed;
    always #50 clock_in = ~clock_in;
    fdg_diag_frame #(.ID_FAMILY(FAM)) DUT (
        .clock_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'b010),
        .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
        .freeze_cmd_in, .sync_cmd_in, .diag_req_in, .diag_byte_out, .diag_valid_out,
        .diag_last_out, .run_enable_out);
    fdg_master_model mdl (.clock_in, .diag_byte_out, .diag_valid_out, .diag_last_out,
        .diag_req_in, .freeze_cmd_in, .sync_cmd_in);
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict(input bit hung);
        if (hung) error_cnt++;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for the slave's ready
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (hreadyout_out !== 1'b1 && n < 20);
        if (n >= 20) print_verdict(1'b1);
    endtask
    // one single word transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel_in <= 1'b1;
        haddr_in <= {24'h0, a};
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        wait_rdy();
        hsel_in <= 1'b0;
        htrans_in <= 2'b00;
        hwdata_in <= wd;
        wait_rdy();
        v = hrdata_out;
        chk("hresp", 32'h0, {31'h0, hresp_out});
    endtask
    // expected datagram from the shadow state; kind 0 plain, 1 process, 2 state
    function automatic void build(input int kind);
        ex = '{default: 8'h00};
        ex[0] = {4'h0, kind == 2 && rs, 3'h0};
        ex[1] = {ctrl[7], 1'b0, syn, frz, ctrl[3], 1'b1, ctrl[1], ctrl[0]};
        ex[2] = {ctrl[8], 7'h00};
        ex[3] = ctrl[9] ? maddr : 8'hFF;
        ex[4] = FAM;
        ex[5] = vid;
        ex[6] = 8'h42;
        ex[7] = {4'h0, rng};
        ex[8] = 8'h05;
        ex[9] = 8'h82;
        ex[12] = {{2{rng[3]}}, {2{rng[2]}}, {2{rng[1]}}, {2{rng[0]}}};
        if (kind != 0) begin
            ex[13] = 8'h14;
            ex[14] = kind == 1 ? 8'h02 : 8'h01;
            {ex[17], ex[18], ex[19], ex[20]} = adata;
        end
    endfunction
    // request a frame and compare it byte by byte
    task automatic get_frame(input int kind, input int len);
        int n = 0;
        int f0 = mdl.frames;
        build(kind);
        mdl.pulse(0);
        while (mdl.frames == f0 && n < 100) begin
            @(posedge clock_in);
            n++;
        end
        if (n >= 100) print_verdict(1'b1);
        @(posedge clock_in);
        chk("frame length", len, mdl.got_len);
        for (int i = 0; i < len; i++) begin
            chk("frame byte", ex[i], mdl.frame[i]);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(6556);
        repeat (12) @(posedge clock_in);
        reset_n_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        ahb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h0, v);
        ahb(1'b1, 8'h1C, 32'hFFFFFFFF);
        ahb(1'b0, 8'h1C, 32'h0);
        chk("unmapped read", 32'h0, v);
        get_frame(0, 13);
        // freeze and sync commands, then clear
        mdl.pulse(1);
        mdl.pulse(2);
        ahb(1'b0, 8'h18, 32'h0);
        chk("commands seen", 32'h3, {30'h0, v[1:0]});
        frz = 1'b1;
        syn = 1'b1;
        get_frame(0, 13);
        ahb(1'b1, 8'h18, 32'h3);
        frz = 1'b0;
        syn = 1'b0;
        // random control fields, first pass all ones
        for (int k = 0; k < 6; k++) begin
            ctrl = k == 0 ? 10'h3FF : 10'($urandom);
            maddr = 8'($urandom);
            vid = 8'($urandom);
            rng = 4'($urandom);
            ahb(1'b1, 8'h00, {22'h0, ctrl});
            ahb(1'b1, 8'h04, {24'h0, maddr});
            ahb(1'b1, 8'h08, {24'h0, vid});
            ahb(1'b1, 8'h0C, {28'h0, rng});
            chk("run enable", {31'h0, !(ctrl[1] | ctrl[7])}, {31'h0, run_enable_out});
            get_frame(0, 13);
        end
        // process alarm, run-to-stop and stop-to-run state alarms
        for (int k = 1; k < 4; k++) begin
            adata = $urandom;
            rs = k == 2;
            ahb(1'b1, 8'h14, adata);
            ahb(1'b1, 8'h10, k == 1 ? 32'h7 : (rs ? 32'h6 : 32'h2));
            get_frame(k == 1 ? 1 : 2, 33);
            ahb(1'b0, 8'h10, 32'h0);
            chk("alarm cleared", 32'h0, {30'h0, v[1:0]});
        end
        print_verdict(1'b0);
    end
endmodule
bind fdg_diag_frame fdg_diag_frame_props u_props (.clock_in, .reset_n_in, .diag_req_in,
    .diag_byte_out, .diag_valid_out, .diag_last_out);
